// [rtl/tsr_pkg.sv]
// types shared by the tuner synthesizer bus receiver
package tsr_pkg;
   typedef enum logic [2:0] {
      TSR_IDLE,
      TSR_ADDR,
      TSR_ACK_A,
      TSR_WDATA,
      TSR_ACK_W,
      TSR_RDATA,
      TSR_RACK,
      TSR_SKIP
   } tsr_state_t;

   typedef enum logic [1:0] {
      TSR_W_FRESH,
      TSR_W_DIV2,
      TSR_W_BAND
   } tsr_wkind_t;

   typedef struct packed {
      tsr_state_t state;
      logic [2:0] bitcnt;
      logic byte_done;
      logic [7:0] sh;
      logic [7:0] tx;
      logic drive;
      logic rd_ack;
      tsr_wkind_t wkind;
      logic [6:0] div_hi;
      logic [14:0] divider;
      logic [7:0] control;
      logic [7:0] band;
      logic upd;
      logic scl_d;
      logic sda_d;
   } tsr_main_st_t;

   typedef struct packed {
      logic [26:0] sh;
      logic [4:0] cnt;
      logic cl_d;
      logic en_d;
      logic valid;
      logic [26:0] data;
      logic [4:0] len;
   } tsr_w3_st_t;
endpackage

// [rtl/tsr_regs.svh]
// constants for the tuner synthesizer bus receiver
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH
// ****************************************
// addressing
// ****************************************
`define TSR_ADDR_HI 5'h18
`define TSR_RW_POS 0
// ****************************************
// byte fields and reset values
// ****************************************
`define TSR_DIV_FLAG_POS 7
`define TSR_RSB_POS 1
`define TSR_CTRL_RST 8'h82
`define TSR_BAND_RST 8'h00
`define TSR_DIV_RST 15'h0000
// ****************************************
// 3-wire frames
// ****************************************
`define TSR_LEN_SHORT 5'h12
`define TSR_LEN_MID 5'h13
`define TSR_LEN_LONG 5'h1B
`define TSR_LEN_MAX 5'h1F
`define TSR_BAND18_LSB 14
`define TSR_BAND19_LSB 15
`define TSR_CTRL27_LSB 19
`endif

// [rtl/tsr_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module tsr_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } tsr_sync_st_t;

   tsr_sync_st_t st_ff;
   tsr_sync_st_t nxt_st;

   // ****************************************
   // stages
   // ****************************************
   always_comb
   begin
      nxt_st.meta = pin_i;
      nxt_st.stab = st_ff.meta;
   end

   // idle bus lines float high
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         st_ff <= '1;
      else
         st_ff <= nxt_st;
   end

   assign sync_o = st_ff.stab;
endmodule

// [rtl/tsr_top.sv]
// tuner synthesizer bus receiver: I2C slave and 3-wire frame decoder
`timescale 1ns/1ns
`include "tsr_regs.svh"
// Notes on behaviour
// [RULE1] format pin high: I2C slave, ack address, data
// [RULE2] full write accepted in either byte order
// [RULE3] shortened writes: divider, control+band, control only
// [RULE4] after read address ack, send status byte
// [RULE5] keep sending status while master acknowledges
// [RULE6] address chosen by address-select input level
// [RULE7] format pin open: use 3-wire protocol
// [RULE8] 3-wire frames of 18, 19, 27 bits
// [RULE9] reset sets ratio select bit to one
// [RULE10] cleared ratio select bit persists over short frames
// [RULE11] foreign address: no ack, ignore until start
// [RULE12] bytes not carried keep previous values
module tsr_top (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic bus_format_select_i,
   input wire logic [1:0] chip_enable_addr_select_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic [7:0] status_i,
   output logic [14:0] divider_o,
   output logic [7:0] control_o,
   output logic [7:0] band_o,
   output logic ref_ratio_select_bit_o,
   output logic update_o
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [4:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic fmt_i2c;
   logic [1:0] asel_s;

   tsr_sync #(
      .W(5)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i({chip_enable_addr_select_i, bus_format_select_i, sda_i, scl_i}),
      .sync_o(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   // open pin reads low through the comparator, so low selects 3-wire
   assign fmt_i2c = pins_s[2]; // [RULE1] [RULE7]
   assign asel_s = pins_s[4:3];

   // ****************************************
   // 3-wire receiver
   // ****************************************
   logic w3_valid;
   logic [4:0] w3_len;
   logic [26:0] w3_data;

   // in 3-wire mode the upper address-select comparator is the enable
   tsr_wire3 u_wire3 (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .active_i(!fmt_i2c), // [RULE7]
      .cl_i(scl_s),
      .da_i(sda_s),
      .en_i(asel_s[1]),
      .frame_valid_o(w3_valid),
      .frame_len_o(w3_len),
      .frame_data_o(w3_data)
   );

   // ****************************************
   // state
   // ****************************************
   tsr_pkg::tsr_main_st_t st_ff;
   tsr_pkg::tsr_main_st_t nxt_st;
   tsr_pkg::tsr_main_st_t rst_st;

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [7:0] own_addr;
   logic addr_match;

   assign scl_rise = scl_s && !st_ff.scl_d;
   assign scl_fall = !scl_s && st_ff.scl_d;
   assign start_det = scl_s && st_ff.scl_d && !sda_s && st_ff.sda_d;
   assign stop_det = scl_s && st_ff.scl_d && sda_s && !st_ff.sda_d;
   assign own_addr = {`TSR_ADDR_HI, asel_s, 1'b0}; // [RULE6]
   // direction bit is excluded from the compare
   assign addr_match = (st_ff.sh[7:1] == own_addr[7:1]); // [RULE6]

   always_comb
   begin
      rst_st = '0;
      rst_st.state = tsr_pkg::TSR_IDLE;
      rst_st.wkind = tsr_pkg::TSR_W_FRESH;
      rst_st.divider = `TSR_DIV_RST;
      rst_st.control = `TSR_CTRL_RST; // [RULE9]
      rst_st.band = `TSR_BAND_RST;
      rst_st.scl_d = 1'b1;
      rst_st.sda_d = 1'b1;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.upd = 1'b0;
      nxt_st.scl_d = scl_s;
      nxt_st.sda_d = sda_s;
      if (!fmt_i2c)
      begin
         nxt_st.state = tsr_pkg::TSR_IDLE;
         nxt_st.drive = 1'b0;
         if (w3_valid)
         begin
            nxt_st.upd = 1'b1;
            if (w3_len == `TSR_LEN_SHORT)
            begin
               nxt_st.divider = {1'b0, w3_data[13:0]};
               nxt_st.band[3:0] = w3_data[`TSR_BAND18_LSB +: 4];
            end
            else
            begin
               nxt_st.divider = w3_data[14:0];
               nxt_st.band[3:0] = w3_data[`TSR_BAND19_LSB +: 4];
            end
            // short frames leave the ratio select bit alone
            if (w3_len == `TSR_LEN_LONG)
               nxt_st.control = w3_data[`TSR_CTRL27_LSB +: 8]; // [RULE10]
         end
      end
      else if (start_det)
      begin
         nxt_st.state = tsr_pkg::TSR_ADDR; // [RULE11]
         nxt_st.bitcnt = 3'h0;
         nxt_st.byte_done = 1'b0;
         nxt_st.drive = 1'b0;
         nxt_st.wkind = tsr_pkg::TSR_W_FRESH;
      end
      else if (stop_det)
      begin
         nxt_st.state = tsr_pkg::TSR_IDLE; // [RULE3]
         nxt_st.drive = 1'b0;
      end
      else
      begin
         unique case (st_ff.state)
            tsr_pkg::TSR_IDLE, tsr_pkg::TSR_SKIP:
            begin
               nxt_st.drive = 1'b0;
            end
            tsr_pkg::TSR_ADDR, tsr_pkg::TSR_WDATA:
            begin
               if (scl_rise)
               begin
                  nxt_st.sh = {st_ff.sh[6:0], sda_s};
                  nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
                  nxt_st.byte_done = (st_ff.bitcnt == 3'h7);
               end
               else if (scl_fall && st_ff.byte_done)
               begin
                  nxt_st.byte_done = 1'b0;
                  nxt_st.bitcnt = 3'h0;
                  if (st_ff.state == tsr_pkg::TSR_ADDR)
                  begin
                     if (addr_match)
                     begin
                        nxt_st.state = tsr_pkg::TSR_ACK_A; // [RULE1]
                        nxt_st.drive = 1'b1;
                     end
                     else
                     begin
                        nxt_st.state = tsr_pkg::TSR_SKIP; // [RULE11]
                     end
                  end
                  else
                  begin
                     nxt_st.state = tsr_pkg::TSR_ACK_W; // [RULE1]
                     nxt_st.drive = 1'b1;
                     nxt_st.upd = 1'b1;
                     unique case (st_ff.wkind)
                        tsr_pkg::TSR_W_DIV2:
                        begin
                           nxt_st.divider = {st_ff.div_hi, st_ff.sh};
                           nxt_st.wkind = tsr_pkg::TSR_W_FRESH;
                        end
                        tsr_pkg::TSR_W_BAND:
                        begin
                           nxt_st.band = st_ff.sh;
                           nxt_st.wkind = tsr_pkg::TSR_W_FRESH;
                        end
                        default:
                        begin
                           // leading bit picks divider pair or control pair
                           if (!st_ff.sh[`TSR_DIV_FLAG_POS]) // [RULE2]
                           begin
                              // divider held back until both halves arrive
                              nxt_st.div_hi = st_ff.sh[6:0]; // [RULE12]
                              nxt_st.wkind = tsr_pkg::TSR_W_DIV2;
                              nxt_st.upd = 1'b0;
                           end
                           else
                           begin
                              nxt_st.control = st_ff.sh; // [RULE3]
                              nxt_st.wkind = tsr_pkg::TSR_W_BAND;
                           end
                        end
                     endcase
                  end
               end
            end
            tsr_pkg::TSR_ACK_A:
            begin
               if (scl_fall)
               begin
                  if (st_ff.sh[`TSR_RW_POS])
                  begin
                     nxt_st.state = tsr_pkg::TSR_RDATA; // [RULE4]
                     nxt_st.tx = status_i;
                     nxt_st.drive = !status_i[7];
                  end
                  else
                  begin
                     nxt_st.state = tsr_pkg::TSR_WDATA;
                     nxt_st.drive = 1'b0;
                  end
               end
            end
            tsr_pkg::TSR_ACK_W:
            begin
               if (scl_fall)
               begin
                  nxt_st.state = tsr_pkg::TSR_WDATA;
                  nxt_st.drive = 1'b0;
               end
            end
            tsr_pkg::TSR_RDATA:
            begin
               if (scl_fall)
               begin
                  if (st_ff.bitcnt == 3'h7)
                  begin
                     nxt_st.state = tsr_pkg::TSR_RACK;
                     nxt_st.drive = 1'b0;
                     nxt_st.bitcnt = 3'h0;
                  end
                  else
                  begin
                     nxt_st.tx = {st_ff.tx[6:0], 1'b0};
                     nxt_st.drive = !st_ff.tx[6]; // [RULE4]
                     nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
                  end
               end
            end
            tsr_pkg::TSR_RACK:
            begin
               if (scl_rise)
               begin
                  nxt_st.rd_ack = !sda_s;
               end
               else if (scl_fall)
               begin
                  if (st_ff.rd_ack)
                  begin
                     // fresh status snapshot for every byte
                     nxt_st.state = tsr_pkg::TSR_RDATA; // [RULE5]
                     nxt_st.tx = status_i;
                     nxt_st.drive = !status_i[7];
                  end
                  else
                  begin
                     nxt_st.state = tsr_pkg::TSR_SKIP; // [RULE5]
                  end
               end
            end
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         st_ff <= rst_st;
      else
         st_ff <= nxt_st;
   end

   // ****************************************
   // outputs
   // ****************************************
   // open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = !st_ff.drive;
   assign divider_o = st_ff.divider;
   assign control_o = st_ff.control;
   assign band_o = st_ff.band;
   assign ref_ratio_select_bit_o = st_ff.control[`TSR_RSB_POS]; // [RULE9] [RULE10]
   assign update_o = st_ff.upd;
endmodule

// [rtl/tsr_wire3.sv]
// 3-wire serial frame receiver
`timescale 1ns/1ns
`include "tsr_regs.svh"
module tsr_wire3 (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic active_i,
   input wire logic cl_i,
   input wire logic da_i,
   input wire logic en_i,
   output logic frame_valid_o,
   output logic [4:0] frame_len_o,
   output logic [26:0] frame_data_o
);
   tsr_pkg::tsr_w3_st_t st_ff;
   tsr_pkg::tsr_w3_st_t nxt_st;

   // ****************************************
   // shift and length check
   // ****************************************
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.valid = 1'b0;
      nxt_st.cl_d = cl_i;
      nxt_st.en_d = en_i;
      if (!active_i)
      begin
         nxt_st.cnt = 5'h00;
      end
      else if (en_i && !st_ff.en_d)
      begin
         nxt_st.cnt = 5'h00;
      end
      else if (en_i && cl_i && !st_ff.cl_d)
      begin
         nxt_st.sh = {st_ff.sh[25:0], da_i};
         // saturate so an overlong frame never aliases to a legal length
         if (st_ff.cnt != `TSR_LEN_MAX)
            nxt_st.cnt = st_ff.cnt + 5'h01;
      end
      else if (!en_i && st_ff.en_d)
      begin
         if (st_ff.cnt == `TSR_LEN_SHORT || st_ff.cnt == `TSR_LEN_MID
             || st_ff.cnt == `TSR_LEN_LONG) // [RULE8]
         begin
            nxt_st.valid = 1'b1;
            nxt_st.len = st_ff.cnt;
            nxt_st.data = st_ff.sh;
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign frame_valid_o = st_ff.valid;
   assign frame_len_o = st_ff.len;
   assign frame_data_o = st_ff.data;
endmodule

// [testbench/testbench.sv]
// self-checking bench for the synthesizer bus receiver
`timescale 1ns/1ns
module testbench;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic fmt = 1'b1;
   logic [7:0] status_i = 8'h00;
   logic scl, host_sda, sda_o, sda_oe_n_o, sda_w, ref_ratio_select_bit, update_o;
   logic [1:0] asel;
   logic [14:0] divider_o;
   logic [7:0] control_o, band_o;
   int failures = 0;
   int n_tests = 0;
   int n_upd = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   assign sda_w = host_sda & (sda_oe_n_o | sda_o);
   always @(posedge sys_clk_i)
      if (update_o === 1'b1)
         n_upd++;
   tsr_top u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_format_select_i(fmt),
      .chip_enable_addr_select_i(asel), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .status_i(status_i), .divider_o(divider_o),
      .control_o(control_o), .band_o(band_o), .ref_ratio_select_bit_o(ref_ratio_select_bit),
      .update_o(update_o));
   tsr_host u_host (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda),
      .asel_o(asel));
   // ****
   // helpers
   // ****
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic regs(input logic [14:0] d, input logic [7:0] c, input logic [7:0] b);
      chk("divider", {17'h0, divider_o}, {17'h0, d});
      chk("control", {24'h0, control_o}, {24'h0, c});
      chk("band", {24'h0, band_o}, {24'h0, b});
      chk("ratio bit", {31'h0, ref_ratio_select_bit}, {31'h0, c[1]});
   endtask
   task automatic do_reset();
      resetn_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
   endtask
   task automatic wr(input logic [7:0] q[$], output logic all_ack);
      logic a;
      all_ack = 1'b1;
      u_host.start();
      foreach (q[i])
      begin
         u_host.wbyte(q[i], a);
         all_ack &= a;
      end
      u_host.stop();
   endtask
   task automatic frame(input logic [26:0] d, input int n, input int upd);
      int u0;
      u0 = n_upd;
      u_host.frame3(d, n);
      chk("frame updates", 32'(n_upd - u0), 32'(upd));
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_writes();
      logic a;
      int u0;
      u0 = n_upd;
      wr('{8'hC2, 8'h06, 8'h40, 8'hCE, 8'h09}, a);
      chk("ack", {31'h0, a}, 32'h1);
      regs(15'h0640, 8'hCE, 8'h09);
      // lone first divider byte lands nothing, so three pulses
      chk("write updates", 32'(n_upd - u0), 32'h3);
      wr('{8'hC2, 8'h8A, 8'h05, 8'h12, 8'h34}, a);
      regs(15'h1234, 8'h8A, 8'h05);
      wr('{8'hC2, 8'h07, 8'h50}, a);
      regs(15'h0750, 8'h8A, 8'h05);
      wr('{8'hC2, 8'hCC, 8'h0F}, a);
      regs(15'h0750, 8'hCC, 8'h0F);
      wr('{8'hC2, 8'hC8}, a);
      regs(15'h0750, 8'hC8, 8'h0F);
   endtask
   task automatic t_addresses();
      logic a;
      logic [7:0] adr;
      logic [14:0] d;
      d = 15'h0750;
      for (int s = 0; s < 4; s++)
      begin
         u_host.asel_o = s[1:0];
         repeat (4) @(negedge sys_clk_i);
         adr = {5'h18, s[1:0], 1'b0};
         wr('{adr + 8'h02, 8'h00, 8'h11}, a);
         chk("foreign ack", {31'h0, a}, 32'h0);
         chk("foreign div", {17'h0, divider_o}, {17'h0, d});
         wr('{adr, 8'h01, 8'(s)}, a);
         d = 15'h0100 + 15'(s);
         chk("addr ack", {31'h0, a}, 32'h1);
         chk("addr div", {17'h0, divider_o}, {17'h0, d});
      end
      u_host.asel_o = 2'h1;
      repeat (4) @(negedge sys_clk_i);
   endtask
   task automatic t_read();
      logic a;
      logic [7:0] b;
      status_i = 8'hA5;
      u_host.start();
      u_host.wbyte(8'hC3, a);
      chk("read ack", {31'h0, a}, 32'h1);
      u_host.rbyte(b);
      chk("status 1", {24'h0, b}, 32'hA5);
      status_i = 8'h3C;
      u_host.bit_out(1'b0);
      u_host.rbyte(b);
      chk("status 2", {24'h0, b}, 32'h3C);
      u_host.bit_out(1'b1);
      u_host.stop();
      chk("released", {31'h0, sda_oe_n_o}, 32'h1);
   endtask
   task automatic t_wire3();
      logic a;
      fmt = 1'b0;
      do_reset();
      regs(15'h0000, 8'h82, 8'h00);
      frame(27'h0049234, 19, 1);
      regs(15'h1234, 8'h82, 8'h09);
      frame(27'h0018ABC, 18, 1);
      regs(15'h0ABC, 8'h82, 8'h06);
      frame(27'h401A222, 27, 1);
      regs(15'h2222, 8'h80, 8'h03);
      // divider word already scaled for the 640 ratio
      frame(27'h0014100, 18, 1);
      regs(15'h0100, 8'h80, 8'h05);
      frame(27'h00FFFFF, 20, 0);
      regs(15'h0100, 8'h80, 8'h05);
      wr('{8'hC2, 8'h06, 8'h40}, a);
      chk("3-wire no ack", {31'h0, a}, 32'h0);
      regs(15'h0100, 8'h80, 8'h05);
      fmt = 1'b1;
   endtask
   initial
   begin
      do_reset();
      regs(15'h0000, 8'h82, 8'h00);
      t_writes();
      t_addresses();
      t_read();
      t_wire3();
      complete_run();
   end
   initial
   begin
      repeat (60000) @(posedge sys_clk_i);
      failures++;
      complete_run();
   end
endmodule

// [testbench/tsr_host.sv]
// host master model for two-wire and 3-wire pins
`timescale 1ns/1ns
module tsr_host (
   input wire logic sys_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output logic [1:0] asel_o
);
   // ****
   // bit level
   // ****
   localparam int H = 8;
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      asel_o = 2'h1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // data only moves 2 cycles after clock fall, never with it
   task automatic bit_out(input logic v);
      sda_o = v;
      hold(H);
      scl_o = 1'b1;
      hold(H);
      scl_o = 1'b0;
      hold(2);
   endtask
   task automatic bit_in(output logic v);
      sda_o = 1'b1;
      hold(H);
      scl_o = 1'b1;
      hold(H / 2);
      v = sda_i;
      hold(H / 2);
      scl_o = 1'b0;
      hold(2);
   endtask
   task automatic start();
      sda_o = 1'b1;
      hold(H);
      scl_o = 1'b1;
      hold(H);
      sda_o = 1'b0;
      hold(H);
      scl_o = 1'b0;
      hold(2);
   endtask
   task automatic stop();
      sda_o = 1'b0;
      hold(H);
      scl_o = 1'b1;
      hold(H);
      sda_o = 1'b1;
      hold(H);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_out(b[i]);
      bit_in(a);
      ack = ~a;
   endtask
   task automatic rbyte(output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         bit_in(b[i]);
   endtask
   // clock stands low outside frames; data shows inverse after
   task automatic frame3(input logic [26:0] d, input int n);
      scl_o = 1'b0;
      asel_o[1] = 1'b1;
      hold(H);
      for (int i = n - 1; i >= 0; i--)
         bit_out(d[i]);
      hold(H);
      asel_o[1] = 1'b0;
      sda_o = ~d[0];
      hold(2 * H);
   endtask
endmodule

// [testbench/tsr_top_assertions.sv]
// port checker for the synthesizer bus receiver
`timescale 1ns/1ns
module tsr_checker (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic bus_format_select_i,
   input wire logic [1:0] chip_enable_addr_select_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic [7:0] status_i,
   input wire logic [14:0] divider_o,
   input wire logic [7:0] control_o,
   input wire logic [7:0] band_o,
   input wire logic ref_ratio_select_bit_o,
   input wire logic update_o
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge sys_clk_i);
   endclocking
   // reset itself is the cause here, so no disable
   property p_rst;
      !resetn_i |=> control_o == 8'h82 && ref_ratio_select_bit_o && divider_o == 15'h0000
         && band_o == 8'h00 && sda_oe_n_o && !update_o;
   endproperty
   property p_rsb;
      disable iff (!resetn_i) $changed(ref_ratio_select_bit_o) |-> update_o;
   endproperty
   property p_keep;
      disable iff (!resetn_i) $changed({divider_o, control_o, band_o}) |-> update_o;
   endproperty
   property p_pulse;
      disable iff (!resetn_i) update_o |=> !update_o;
   endproperty
   property p_w3_upd;
      disable iff (!resetn_i) update_o && !bus_format_select_i
         |-> !chip_enable_addr_select_i[1] && !$past(chip_enable_addr_select_i[1], 3);
   endproperty
   property p_fmt;
      disable iff (!resetn_i) !bus_format_select_i [*4] |-> sda_oe_n_o;
   endproperty
   property p_edge;
      disable iff (!resetn_i) $changed(sda_oe_n_o) |-> !scl_i;
   endproperty
   property p_stand;
      disable iff (!resetn_i) $fell(sda_oe_n_o) |=> !sda_oe_n_o [*8];
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_rsb: assert property (p_rsb) else $error("ratio bit moved alone");
   a_keep: assert property (p_keep) else $error("output moved alone");
   a_pulse: assert property (p_pulse) else $error("update too long");
   a_w3_upd: assert property (p_w3_upd) else $error("frame update early");
   a_fmt: assert property (p_fmt) else $error("data driven in 3-wire");
   a_edge: assert property (p_edge) else $error("data moved, clock high");
   a_stand: assert property (p_stand) else $error("low drive too short");
   c_i2c: cover property (disable iff (!resetn_i) update_o && bus_format_select_i);
   c_w3: cover property (disable iff (!resetn_i) update_o && !bus_format_select_i);
   c_drv: cover property (disable iff (!resetn_i) $fell(sda_oe_n_o));
endmodule
bind tsr_top tsr_checker u_chk (
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_format_select_i(bus_format_select_i),
   .chip_enable_addr_select_i(chip_enable_addr_select_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .status_i(status_i), .divider_o(divider_o),
   .control_o(control_o), .band_o(band_o), .ref_ratio_select_bit_o(ref_ratio_select_bit_o),
   .update_o(update_o)
);
